//--- shared/ssrm_pkg.sv
// Constants, types and address helpers for the shadowed serial register map
// Notes on behaviour
// R1 - Fixed address ranges for config, index, functions, link
// R2 - Every register location is one byte
// R3 - Shadowed writes act only after transfer
// R4 - Writing 0x01 to 0xFF sets transfer
// R5 - Transfer copies all shadows, then self-clears
// R6 - Local registers duplicated, chosen by channel index
// R7 - Both select bits write both copies
// R8 - Host selects one channel before local reads; the testbench also reads local registers with both selected
// R9 - Both selected on read returns copy A
// R10 - Global registers ignore channel select bits
// R11 - Any reset loads default register values
// R12 - Host writes zero into open bits
// R13 - Host never writes fully open addresses
// R14 - Port config nibbles mirrored, default 0x18
// R15 - Host sets all selects before port config
// R16 - Frame opens with 16-bit instruction, read flag first
// R17 - Bytes shift MSB first until LSB chosen
// R18 - Chip select low plus clock rise starts frame
// R19 - Unsupported locations read zero, ignore writes
// R20 - Chip identifier fixed, writes ignored
package ssrm_pkg;

  // ==========================================================================
  // Addresses
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_IDENTIFIER = 13'h0001;
  localparam logic [12:0] ADDR_GRADE = 13'h0002;
  localparam logic [12:0] ADDR_CHAN_IDX = 13'h0005;
  localparam logic [12:0] ADDR_XFER = 13'h00FF;
  localparam logic [12:0] ADC_FIRST = 13'h0008;
  localparam logic [12:0] ADC_LAST = 13'h003A;
  localparam logic [12:0] LINK_FIRST = 13'h005E;
  localparam logic [12:0] LINK_LAST = 13'h0079;
  localparam logic [12:0] GLOBAL_FIRST = 13'h0009;
  localparam logic [12:0] GLOBAL_LAST = 13'h000B;
  localparam logic [12:0] ADC_SLOTS = 13'h0033;
  localparam int SLOTS = 79;
  localparam int GCLK_SLOT = 1;

  // ==========================================================================
  // Field positions and reset values
  localparam int PC_LSB_HI = 6;
  localparam int PC_LSB_LO = 1;
  localparam int PC_SRST_HI = 5;
  localparam int PC_SRST_LO = 2;
  localparam int XFER_BIT = 0;
  localparam logic [7:0] XFER_CMD = 8'h01;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] GCLK_RST = 8'h01;
  localparam logic [1:0] CHAN_IDX_RST = 2'h3;
  localparam logic LSB_FIRST_RST = 1'b0;
  localparam logic [2:0] PIN_RST = 3'h2;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic rd;
    logic [1:0] len;
    logic [12:0] addr;
  } ssrm_instr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_WDATA, ST_RDATA, ST_DONE} ssrm_state_t;

  // ==========================================================================
  // Address helpers
  function automatic logic in_shadow(input logic [12:0] a);
    return (a >= ADC_FIRST && a <= ADC_LAST) || (a >= LINK_FIRST && a <= LINK_LAST); // R1
  endfunction

  function automatic logic is_local(input logic [12:0] a);
    return in_shadow(a) && !(a >= GLOBAL_FIRST && a <= GLOBAL_LAST);
  endfunction

  function automatic logic [6:0] slot_of(input logic [12:0] a);
    logic [12:0] s;
    s = (a <= ADC_LAST) ? 13'(a - ADC_FIRST) : 13'(a - LINK_FIRST + ADC_SLOTS);
    return s[6:0];
  endfunction

  function automatic logic [7:0] slot_default(input int i);
    return (i == GCLK_SLOT) ? GCLK_RST : 8'h00;
  endfunction

endpackage

//--- design/ssrm_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ssrm_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] din,
  output logic [2:0] dout
);

  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      always_ff @(posedge clock) begin
        if (rst) begin
          s1[i] <= ssrm_pkg::PIN_RST[i];
          s2[i] <= ssrm_pkg::PIN_RST[i];
          s3[i] <= ssrm_pkg::PIN_RST[i];
          dout[i] <= ssrm_pkg::PIN_RST[i];
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // Only a level seen twice in a row is taken
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule

//--- design/ssrm_bank.sv
// One channel's staged and active copies of the shadowed registers
`timescale 1ns/10ps
module ssrm_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire logic [6:0] wr_slot,
  input wire logic [7:0] wr_data,
  input wire logic commit,
  output logic [ssrm_pkg::SLOTS-1:0][7:0] shadow,
  output logic [ssrm_pkg::SLOTS-1:0][7:0] active
);

  genvar i;
  generate
    for (i = 0; i < ssrm_pkg::SLOTS; i++) begin : g_slot
      always_ff @(posedge clock) begin
        if (rst || soft_rst) begin
          shadow[i] <= ssrm_pkg::slot_default(i); // R11
        end else if (wr_en && wr_slot == 7'(i)) begin
          shadow[i] <= wr_data; // R3
        end
      end

      always_ff @(posedge clock) begin
        if (rst || soft_rst) begin
          active[i] <= ssrm_pkg::slot_default(i); // R11
        end else if (commit) begin
          active[i] <= shadow[i]; // R5
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_COMMIT_COPY: assert property (commit && !soft_rst |=> active == $past(shadow)) // R5
    else $error("active copy differs from staged copy after commit");
  AST_ACTIVE_HOLD: assert property (!commit && !soft_rst |=> $stable(active)) // R3
    else $error("active copy moved without commit");

endmodule

//--- design/ssrm_top.sv
// Serial port frame engine and register map with shadowed channel banks
`timescale 1ns/10ps
module ssrm_top #(
  // Arbitrary neutral identification value
  parameter logic [7:0] CHIP_IDENTIFIER = 8'hA5,
  parameter logic [1:0] SPEED_GRADE = 2'h0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic [ssrm_pkg::SLOTS-1:0][7:0] active_a,
  output logic [ssrm_pkg::SLOTS-1:0][7:0] active_b
);

  // ==========================================================================
  // Pin conditioning
  logic [2:0] pins_f;
  logic sclk_f;
  logic cs_f;
  logic sdi_f;
  logic sclk_q;
  logic rise;
  logic fall;

  ssrm_sync u_sync (
    .clock(clock),
    .rst(rst),
    .din({sdio_in, chip_select_n, sclk}),
    .dout(pins_f)
  );

  assign sclk_f = pins_f[0];
  assign cs_f = pins_f[1];
  assign sdi_f = pins_f[2];

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_f;
    end
  end

  // All three pins share one delay, so data stays aligned to its clock edge
  assign rise = sclk_f && !sclk_q;
  assign fall = !sclk_f && sclk_q;

  // ==========================================================================
  // Frame engine
  ssrm_pkg::ssrm_state_t state;
  ssrm_pkg::ssrm_instr_t instr;
  ssrm_pkg::ssrm_instr_t next_instr;
  logic [15:0] instr_sh;
  logic [3:0] cnt;
  logic [1:0] bytes;
  logic [12:0] addr;
  logic [12:0] next_addr;
  logic [12:0] rd_addr;
  logic in_instr;
  logic instr_done;
  logic byte_done;
  logic last_byte;
  logic lsb_first;

  assign in_instr = (state == ssrm_pkg::ST_IDLE) || (state == ssrm_pkg::ST_INSTR);
  // Instruction always arrives read flag first
  assign next_instr = {instr_sh[14:0], sdi_f}; // R16
  assign instr_done = rise && in_instr && cnt == ssrm_pkg::INSTR_LAST_BIT;
  assign byte_done = rise && cnt == ssrm_pkg::BYTE_LAST_BIT &&
                     (state == ssrm_pkg::ST_WDATA || state == ssrm_pkg::ST_RDATA);
  assign last_byte = instr.len != ssrm_pkg::LEN_STREAM && bytes == instr.len;
  // Streaming walks down in MSB-first mode and up in LSB-first mode
  assign next_addr = lsb_first ? 13'(addr + 13'h0001) : 13'(addr - 13'h0001);
  assign rd_addr = in_instr ? next_instr.addr : next_addr;

  always_ff @(posedge clock) begin
    if (rst || cs_f) begin
      state <= ssrm_pkg::ST_IDLE; // R18
      instr_sh <= 16'h0000;
      instr <= '0;
      cnt <= 4'h0;
      bytes <= 2'h0;
      addr <= 13'h0000;
    end else begin
      case (state)
        ssrm_pkg::ST_IDLE, ssrm_pkg::ST_INSTR: begin
          if (rise) begin
            instr_sh <= next_instr;
            cnt <= 4'(cnt + 4'h1);
            state <= ssrm_pkg::ST_INSTR; // R18
            if (instr_done) begin
              instr <= next_instr;
              addr <= next_instr.addr;
              cnt <= 4'h0;
              state <= next_instr.rd ? ssrm_pkg::ST_RDATA : ssrm_pkg::ST_WDATA; // R16
            end
          end
        end
        ssrm_pkg::ST_WDATA, ssrm_pkg::ST_RDATA: begin
          if (rise) begin
            cnt <= 4'(cnt + 4'h1);
          end
          if (byte_done) begin
            cnt <= 4'h0;
            addr <= next_addr;
            bytes <= 2'(bytes + 2'h1);
            if (last_byte) begin
              state <= ssrm_pkg::ST_DONE;
            end
          end
        end
        ssrm_pkg::ST_DONE: begin
          state <= ssrm_pkg::ST_DONE;
        end
        default: begin
          state <= ssrm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Write shifter and strobe
  logic [7:0] wsh;
  logic [7:0] next_wbyte;
  logic wr_en;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;

  assign next_wbyte = lsb_first ? {sdi_f, wsh[7:1]} : {wsh[6:0], sdi_f}; // R17

  always_ff @(posedge clock) begin
    if (rst) begin
      wsh <= 8'h00;
      wr_en <= 1'b0;
      wr_addr <= 13'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (rise && state == ssrm_pkg::ST_WDATA && !cs_f) begin
        wsh <= next_wbyte;
        if (byte_done) begin
          wr_en <= 1'b1;
          wr_addr <= addr;
          wr_data <= next_wbyte;
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0] rd_byte; // R2
  logic [6:0] rd_slot;
  logic [7:0] rsh;
  logic [7:0] cfg_rd;
  logic soft_rst;
  logic [1:0] chan_sel;
  logic xfer;
  logic [ssrm_pkg::SLOTS-1:0][7:0] sh_a;
  logic [ssrm_pkg::SLOTS-1:0][7:0] sh_b;

  always_comb begin
    cfg_rd = ssrm_pkg::PORT_CFG_RST; // R14
    cfg_rd[ssrm_pkg::PC_LSB_HI] = lsb_first; // R14
    cfg_rd[ssrm_pkg::PC_LSB_LO] = lsb_first;
    cfg_rd[ssrm_pkg::PC_SRST_HI] = soft_rst;
    cfg_rd[ssrm_pkg::PC_SRST_LO] = soft_rst;
  end

  always_comb begin
    rd_byte = 8'h00;
    rd_slot = ssrm_pkg::slot_of(rd_addr);
    if (ssrm_pkg::in_shadow(rd_addr)) begin
      // Reads show the staged copy, so software can verify before commit
      if (ssrm_pkg::is_local(rd_addr) && !chan_sel[0] && chan_sel[1]) begin
        rd_byte = sh_b[rd_slot]; // R6
      end else begin
        rd_byte = sh_a[rd_slot]; // R9
      end
    end else begin
      case (rd_addr) // R1
        ssrm_pkg::ADDR_PORT_CFG: rd_byte = cfg_rd;
        ssrm_pkg::ADDR_CHIP_IDENTIFIER: rd_byte = CHIP_IDENTIFIER; // R20
        ssrm_pkg::ADDR_GRADE: rd_byte = {2'h0, SPEED_GRADE, 4'h0};
        ssrm_pkg::ADDR_CHAN_IDX: rd_byte = {6'h00, chan_sel};
        ssrm_pkg::ADDR_XFER: rd_byte[ssrm_pkg::XFER_BIT] = xfer;
        default: rd_byte = 8'h00; // R19
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || cs_f) begin
      rsh <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      if ((instr_done && next_instr.rd) || (byte_done && state == ssrm_pkg::ST_RDATA)) begin
        rsh <= rd_byte;
      end else if (fall && state == ssrm_pkg::ST_RDATA) begin
        sdio_out <= lsb_first ? rsh[0] : rsh[7]; // R17
        rsh <= lsb_first ? {1'b0, rsh[7:1]} : {rsh[6:0], 1'b0};
        sdio_oe <= 1'b1;
      end
      // Drop the pin in the cycle the last byte ends, not one later
      if (state != ssrm_pkg::ST_RDATA || (byte_done && last_byte)) begin
        sdio_oe <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Directly mapped registers
  logic wr_map;
  logic wr_local;
  logic we_a;
  logic we_b;
  logic [6:0] wr_slot;

  assign wr_map = wr_en && ssrm_pkg::in_shadow(wr_addr);
  assign wr_local = ssrm_pkg::is_local(wr_addr);
  assign wr_slot = ssrm_pkg::slot_of(wr_addr);
  assign we_a = wr_map && (!wr_local || chan_sel[0]); // R10
  assign we_b = wr_map && wr_local && chan_sel[1]; // R7

  always_ff @(posedge clock) begin
    if (rst || soft_rst) begin
      lsb_first <= ssrm_pkg::LSB_FIRST_RST; // R11
      chan_sel <= ssrm_pkg::CHAN_IDX_RST;
    end else if (wr_en && wr_addr == ssrm_pkg::ADDR_PORT_CFG) begin
      lsb_first <= wr_data[ssrm_pkg::PC_LSB_HI] | wr_data[ssrm_pkg::PC_LSB_LO]; // R14
    end else if (wr_en && wr_addr == ssrm_pkg::ADDR_CHAN_IDX) begin
      chan_sel <= wr_data[1:0]; // R6
    end
  end

  // Soft reset pulses one cycle and then clears itself with everything else
  always_ff @(posedge clock) begin
    if (rst || soft_rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_en && wr_addr == ssrm_pkg::ADDR_PORT_CFG &&
                  (wr_data[ssrm_pkg::PC_SRST_HI] | wr_data[ssrm_pkg::PC_SRST_LO]); // R14
    end
  end

  // A new command in the clearing cycle sets the bit again
  always_ff @(posedge clock) begin
    if (rst || soft_rst) begin
      xfer <= 1'b0;
    end else begin
      xfer <= wr_en && wr_addr == ssrm_pkg::ADDR_XFER && wr_data == ssrm_pkg::XFER_CMD; // R4 R5
    end
  end

  // ==========================================================================
  // Channel banks
  ssrm_bank u_bank_a (
    .clock(clock),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(we_a),
    .wr_slot(wr_slot),
    .wr_data(wr_data),
    .commit(xfer),
    .shadow(sh_a),
    .active(active_a)
  );

  ssrm_bank u_bank_b (
    .clock(clock),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(we_b),
    .wr_slot(wr_slot),
    .wr_data(wr_data),
    .commit(xfer),
    .shadow(sh_b),
    .active(active_b)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_XFER_SET: assert property (wr_en && wr_addr == ssrm_pkg::ADDR_XFER && // R4
                                 wr_data == ssrm_pkg::XFER_CMD && !soft_rst |=> xfer)
    else $error("transfer command did not set transfer bit");
  AST_XFER_AUTOCLEAR: assert property (xfer && !wr_en |=> !xfer) // R5
    else $error("transfer bit did not clear itself");
  AST_BOTH_WRITE: assert property (wr_map && wr_local && chan_sel == 2'h3 && !soft_rst // R7
                                   |=> sh_a[wr_slot] == wr_data && sh_b[wr_slot] == wr_data)
    else $error("write with both selects missed a copy");
  AST_B_ONLY: assert property (we_b && !we_a && !soft_rst // R6
                               |=> sh_a[wr_slot] == $past(sh_a[wr_slot]))
    else $error("channel B write touched copy A");
  AST_READ_BOTH_A: assert property (ssrm_pkg::is_local(rd_addr) && chan_sel == 2'h3 // R9
                                    |-> rd_byte == sh_a[rd_slot])
    else $error("read with both selects did not return copy A");
  AST_GLOBAL_IGNORE: assert property (wr_map && !wr_local && chan_sel == 2'h2 && !soft_rst // R10
                                      |=> sh_a[wr_slot] == wr_data)
    else $error("global write depended on channel selects");
  AST_CFG_MIRROR: assert property (cfg_rd[4:3] == 2'h3 && !cfg_rd[7] && !cfg_rd[0] && // R14
                                   cfg_rd[6] == cfg_rd[1] && cfg_rd[5] == cfg_rd[2])
    else $error("port configuration readback not mirrored");
  AST_RESET_DEFAULT: assert property ($past(rst) |-> cfg_rd == ssrm_pkg::PORT_CFG_RST && // R11
                                      chan_sel == ssrm_pkg::CHAN_IDX_RST && !lsb_first)
    else $error("defaults not loaded after reset");
  AST_SOFT_RESET: assert property (soft_rst |=> chan_sel == ssrm_pkg::CHAN_IDX_RST && // R11
                                   !lsb_first && !soft_rst)
    else $error("soft reset did not restore defaults");
  AST_CHIP_IDENTIFIER: assert property (rd_addr == ssrm_pkg::ADDR_CHIP_IDENTIFIER |-> rd_byte == CHIP_IDENTIFIER) // R20
    else $error("chip identifier read wrong");
  AST_UNMAPPED_ZERO: assert property (rd_addr > ssrm_pkg::ADDR_XFER |-> rd_byte == 8'h00) // R19
    else $error("unsupported address read nonzero");
  AST_OE_READ_ONLY: assert property (sdio_oe |-> state == ssrm_pkg::ST_RDATA) // R16
    else $error("data pin driven outside read data phase");
  AST_CS_ENDS: assert property (cs_f |=> state == ssrm_pkg::ST_IDLE && !sdio_oe) // R18
    else $error("frame not ended by chip select");

  COV_WRITE: cover property (wr_en);
  COV_READ: cover property (sdio_oe ##1 byte_done);
  COV_COMMIT: cover property (xfer);
  COV_SOFT_RESET: cover property (soft_rst);

endmodule

//--- verif/ssrm_host.sv
// Serial host model driving the three-wire port of the register map
`timescale 1ns/10ps
module ssrm_host (
  input wire logic clock,
  output logic sclk,
  output logic chip_select_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic released;

  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdio_in = 1'b0;
    released = 1'b1;
  end

  // ==========================================================================
  // Half serial period of 8 clocks keeps each phase above the 5-clock minimum
  task automatic half();
    repeat (8) begin
      // A released line toggles so a stale bit can never pass for data
      if (released)
        sdio_in <= ~sdio_in;
      @(posedge clock);
    end
  endtask

  // ==========================================================================
  // Bit order swap for LSB-first data bytes
  function automatic logic [7:0] flip(input logic [7:0] v);
    logic [7:0] f;
    int k;
    for (k = 0; k < 8; k++)
      f[k] = v[7 - k];
    return f;
  endfunction

  // ==========================================================================
  // One single-byte frame; the serial clock idles low outside frames
  task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                       input logic lsb, output logic [7:0] rdata, output logic oe_ok);
    logic [23:0] bits;
    int i;
    bits = {rd, 2'b00, addr, (lsb ? flip(wdata) : wdata)};
    oe_ok = 1'b1;
    rdata = 8'h00;
    @(posedge clock);
    chip_select_n <= 1'b0;
    half();
    for (i = 23; i >= 0; i--) begin
      released = rd && (i < 8);
      if (!released)
        sdio_in <= bits[i];
      sclk <= 1'b0;
      half();
      sclk <= 1'b1;
      if (i < 8) begin
        rdata = {rdata[6:0], sdio_out};
        if (sdio_oe !== rd)
          oe_ok = 1'b0;
      end
      half();
    end
    if (lsb)
      rdata = flip(rdata);
    released = 1'b1;
    sclk <= 1'b0;
    half();
    chip_select_n <= 1'b1;
    half();
    half();
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking testbench for the shadowed serial register map
`timescale 1ns/10ps
module tb_top;
  logic clock;
  logic rst;
  logic sclk;
  logic chip_select_n;
  logic sdio_in;
  logic sdio_out;
  logic sdio_oe;
  logic [ssrm_pkg::SLOTS-1:0][7:0] active_a;
  logic [ssrm_pkg::SLOTS-1:0][7:0] active_b;
  logic lsb;
  int n_fail;
  int checks_done;
  // Arbitrary identification value
  localparam logic [7:0] ID = 8'h3A;
  localparam logic [1:0] GRADE = 2'h2;

  ssrm_top #(.CHIP_IDENTIFIER(ID), .SPEED_GRADE(GRADE)) dut (
    .clock(clock),
    .rst(rst),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .active_a(active_a),
    .active_b(active_b)
  );

  ssrm_host host (
    .clock(clock),
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe)
  );

  // ==========================================================================
  // Shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic ok;
    host.frame(1'b0, a, d, lsb, r, ok);
    check({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic ok;
    host.frame(1'b1, a, 8'h00, lsb, r, ok);
    check({7'h00, ok}, 8'h01);
    check(r, exp);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0001, ID);
    rd_chk(13'h0002, {2'b00, GRADE, 4'h0});
    rd_chk(13'h0005, 8'h03);
    rd_chk(13'h00FF, 8'h00);
    check(active_a[1], 8'h01);
    check(active_b[0], 8'h00);
    wr(13'h0001, 8'h00);
    rd_chk(13'h0001, ID);
    rd_chk(13'h0013, 8'h00);
    rd_chk(13'h0004, 8'h00);
    $display("t_defaults done");
  endtask

  task automatic t_shadow();
    logic [12:0] a [4] = '{13'h0008, 13'h003A, 13'h005E, 13'h0079};
    int s [4] = '{0, 50, 51, 78};
    int i;
    for (i = 0; i < 4; i++) begin
      wr(a[i], 8'hA0 + 8'(i));
      check(active_a[s[i]], 8'h00);
      rd_chk(a[i], 8'hA0 + 8'(i));
    end
    wr(13'h00FF, ssrm_pkg::XFER_CMD);
    for (i = 0; i < 4; i++) begin
      check(active_a[s[i]], 8'hA0 + 8'(i));
      check(active_b[s[i]], 8'hA0 + 8'(i));
    end
    rd_chk(13'h00FF, 8'h00);
    $display("t_shadow done");
  endtask

  task automatic t_local();
    wr(13'h0005, 8'h01);
    wr(13'h0008, 8'h11);
    wr(13'h0005, 8'h02);
    wr(13'h0008, 8'h22);
    wr(13'h00FF, 8'h01);
    check(active_a[0], 8'h11);
    check(active_b[0], 8'h22);
    rd_chk(13'h0008, 8'h22);
    wr(13'h0005, 8'h03);
    rd_chk(13'h0008, 8'h11);
    wr(13'h0005, 8'h01);
    rd_chk(13'h0008, 8'h11);
    $display("t_local done");
  endtask

  task automatic t_global();
    wr(13'h0005, 8'h02);
    wr(13'h0009, 8'h00);
    wr(13'h00FF, 8'h01);
    check(active_a[1], 8'h00);
    check(active_b[1], 8'h01);
    rd_chk(13'h0009, 8'h00);
    $display("t_global done");
  endtask

  task automatic t_port();
    wr(13'h0005, 8'h03);
    wr(13'h0000, 8'h5A);
    lsb = 1'b1;
    rd_chk(13'h0000, 8'h5A);
    rd_chk(13'h0001, ID);
    wr(13'h0008, 8'h1E);
    wr(13'h00FF, ssrm_pkg::XFER_CMD);
    check(active_a[0], 8'h1E);
    rd_chk(13'h0008, 8'h1E);
    wr(13'h0000, 8'h3C);
    lsb = 1'b0;
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0008, 8'h00);
    check(active_a[0], 8'h00);
    $display("t_port done");
  endtask

  // ==========================================================================
  // Run control
  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    lsb = 1'b0;
    n_fail = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    t_defaults();
    t_shadow();
    t_local();
    t_global();
    t_port();
    wrap_up();
  end

  // About 45 frames of some 430 clocks each; generous margin
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
